/* File: tb/bwds_link_dev.sv */
`timescale 1ns/1ns
`default_nettype none
module bwds_link_dev (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic fire_in,
  output logic      serr_out
);
  logic [2:0] hold;
  // Held a few cycles so the bridge's synchroniser cannot miss it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      hold <= 3'h0;
    else if (fire_in)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  assign serr_out = (hold != 3'h0);
endmodule : bwds_link_dev
`default_nettype wire

/* File: tb/bwds_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module bridge_window_decode_status_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        io_req = 1'b0;
  logic        mem_req = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [31:0] mem_addr = 32'h0;
  logic [11:0] mem_lim = 12'h000;
  logic        io_hit;
  logic        mem_hit;
  logic        fire = 1'b0;
  logic        serr;
  logic        mab = 1'b0;
  logic        tab = 1'b0;
  int          miscompares = 0;
  int          tests_run = 0;
  logic [7:0]  ra [9] = '{8'h1b,8'h1c,8'h1d,8'h1e,8'h1f,8'h20,8'h21,8'h1a,8'h22};
  logic [7:0]  re [9] = '{8'h00,8'hf0,8'h00,8'ha0,8'h02,8'hf0,8'hff,8'h00,8'h00};

  always #25 clk = ~clk;

  bwds_top DUT (.CORE_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .IO_REQ_IN(io_req), .IO_ADDR_IN(io_addr), .IO_HIT_OUT(io_hit),
    .MEM_REQ_IN(mem_req), .MEM_ADDR_IN(mem_addr), .MEM_LIMIT_IN(mem_lim),
    .MEM_HIT_OUT(mem_hit), .LINK_SERR_IN(serr), .MASTER_ABORT_IN(mab),
    .TARGET_ABORT_IN(tab));
  bwds_link_dev far_dev (.clk_in(clk), .rst_in(rst), .fire_in(fire), .serr_out(serr));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    // One idle edge so a following write never re-raises the strobe in this step
    @(posedge clk);
  endtask : wr_reg

  // Data stands one cycle only, so it is sampled just after that edge
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clk);
  endtask : rd_reg

  task automatic probe(input logic m, input logic [31:0] a, input logic e);
    mem_req <= m;
    io_req <= !m;
    mem_addr <= a;
    io_addr <= a[15:0];
    @(posedge clk);
    mem_req <= 1'b0;
    io_req <= 1'b0;
    #1;
    chk({7'h0, m ? mem_hit : io_hit}, {7'h0, e});
    @(posedge clk);
  endtask : probe

  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++)
      rd_reg(ra[i], re[i]);
    probe(1'b0, 32'h0123, 1'b0);
    $display("reset values done");
    wr_reg(8'h1b, 8'hff);
    wr_reg(8'h1c, 8'hff);
    wr_reg(8'h1d, 8'h5f);
    wr_reg(8'h20, 8'hff);
    wr_reg(8'h1e, 8'hff);
    rd_reg(8'h1b, 8'h00);
    rd_reg(8'h1c, 8'hf0);
    rd_reg(8'h1d, 8'h50);
    rd_reg(8'h20, 8'hf0);
    rd_reg(8'h1e, 8'ha0);
    $display("access kinds done");
    wr <= 1'b1;
    addr <= 8'h1c;
    wdata <= 8'h30;
    @(posedge clk);
    wr <= 1'b0;
    rd_reg(8'h1c, 8'h30);
    wr_reg(8'h1d, 8'h50);
    probe(1'b0, 32'h2fff, 1'b0);
    probe(1'b0, 32'h3000, 1'b1);
    probe(1'b0, 32'h5fff, 1'b1);
    probe(1'b0, 32'h6000, 1'b0);
    $display("io window done");
    wr_reg(8'h20, 8'h50);
    wr_reg(8'h21, 8'h12);
    mem_lim <= 12'h126;
    rd_reg(8'h21, 8'h12);
    probe(1'b1, 32'h124fffff, 1'b0);
    probe(1'b1, 32'h12500000, 1'b1);
    probe(1'b1, 32'h126fffff, 1'b1);
    probe(1'b1, 32'h12700000, 1'b0);
    $display("memory window done");
    mab <= 1'b1;
    @(posedge clk);
    mab <= 1'b0;
    @(posedge clk);
    rd_reg(8'h1f, 8'h22);
    tab <= 1'b1;
    @(posedge clk);
    tab <= 1'b0;
    @(posedge clk);
    rd_reg(8'h1f, 8'h32);
    wr_reg(8'h1f, 8'h00);
    rd_reg(8'h1f, 8'h32);
    wr_reg(8'h1f, 8'h20);
    rd_reg(8'h1f, 8'h12);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(8'h1f, 8'h52);
    wr_reg(8'h1f, 8'hff);
    rd_reg(8'h1f, 8'h02);
    mab <= 1'b1;
    tab <= 1'b1;
    wr <= 1'b1;
    addr <= 8'h1f;
    wdata <= 8'h30;
    @(posedge clk);
    mab <= 1'b0;
    tab <= 1'b0;
    wr <= 1'b0;
    rd_reg(8'h1f, 8'h32);
    $display("error flags done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(8'h1c, 8'hf0);
    rd_reg(8'h21, 8'hff);
    $display("second reset done");
    end_sim();
  end
endmodule : bridge_window_decode_status_tb_top
`default_nettype wire

/* File: verilog/bwds_map.svh */
`ifndef BWDS_MAP_SVH
`define BWDS_MAP_SVH
`define BWDS_OFF_LAT      8'h1b
`define BWDS_OFF_IO_BASE_FIELD   8'h1c
`define BWDS_OFF_IOLIM    8'h1d
`define BWDS_OFF_SSTS_LO  8'h1e
`define BWDS_OFF_SSTS_HI  8'h1f
`define BWDS_OFF_MBASE_LO 8'h20
`define BWDS_OFF_MBASE_HI 8'h21
`define BWDS_RST_LAT      8'h00
`define BWDS_RST_IO_BASE_FIELD   8'hf0
`define BWDS_RST_IOLIM    8'h00
`define BWDS_RST_SSTS     16'h02a0
`define BWDS_RST_MBASE    16'hfff0
`define BWDS_IO_LOW_ZERO  12'h000
`define BWDS_IO_LOW_ONES  12'hfff
`define BWDS_MEM_LOW_ZERO 20'h00000
`define BWDS_MEM_LOW_ONES 20'hfffff
`endif

/* File: verilog/bwds_pkg.sv */
`default_nettype none
package bwds_pkg;
  // Sticky error flags, order matches status bits 14:12
  typedef struct packed {
    logic system_error_received_flag;
    logic master_abort_received_flag;
    logic target_abort_received_flag;
  } bwds_err_t;

  typedef struct packed {
    logic [3:0]  io_base_field;
    logic [3:0]  io_limit_field;
    logic [11:0] mem_base_field;
    bwds_err_t   err;
    logic [2:0]  serr_sync;
    logic [7:0]  rd_data;
    logic        io_hit;
    logic        mem_hit;
  } bwds_state_t;
endpackage : bwds_pkg
`default_nettype wire

/* File: verilog/bwds_top.sv */
// Operation
// - Forward I/O cycle only when base <= address <= limit, inclusive.
// - I/O base at 1Ch holds A[15:12] in bits 7:4; resets F0h.
// - I/O base compare uses A[11:0] as zero.
// - I/O limit compare uses A[11:0] as all ones.
// - I/O limit at 1Dh holds A[15:12] in bits 7:4; resets 00h.
// - Forward memory cycle when memory base <= address <= limit.
// - Memory base bits 15:4 hold A[31:20]; bits 3:0 read zero.
// - Memory base compare uses A[19:0] as zero.
// - Memory base at 20h-21h resets FFF0h.
// - Memory limit compare uses A[19:0] as all ones.
// - Error flags clear only on written one; zero leaves them.
// - Status bit 14 sets on system error from link device.
// - Status bit 13 sets on unexpected master abort.
// - Status bit 12 sets on target abort of own transaction.
// - Status bits 15, 11, 8 always read zero.
// - Status bits 10:9 always read 01b.
// - Status bits 7 and 5 always read one.
// - Secondary status at 1Eh-1Fh resets 02A0h.
// - Latency timer byte at 1Bh reserved, read-only, reads 00h.
`include "bwds_map.svh"
`timescale 1ns/1ns
`default_nettype none
module bwds_top
  import bwds_pkg::*;
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [7:0]  REG_RDATA_OUT,
  input  wire logic        IO_REQ_IN,
  input  wire logic [15:0] IO_ADDR_IN,
  output logic             IO_HIT_OUT,
  input  wire logic        MEM_REQ_IN,
  input  wire logic [31:0] MEM_ADDR_IN,
  input  wire logic [11:0] MEM_LIMIT_IN,
  output logic             MEM_HIT_OUT,
  input  wire logic        LINK_SERR_IN,
  input  wire logic        MASTER_ABORT_IN,
  input  wire logic        TARGET_ABORT_IN
);

  localparam logic [7:0]  IOB_RST = `BWDS_RST_IO_BASE_FIELD;
  localparam logic [7:0]  IOL_RST = `BWDS_RST_IOLIM;
  localparam logic [15:0] MB_RST  = `BWDS_RST_MBASE;
  localparam logic [15:0] SS_RST  = `BWDS_RST_SSTS;

  localparam bwds_state_t STATE_RST = '{
    io_base_field:  IOB_RST[7:4],
    io_limit_field: IOL_RST[7:4],
    mem_base_field: MB_RST[15:4],
    err:            '0,
    serr_sync:      3'h0,
    rd_data:        8'h00,
    io_hit:         1'b0,
    mem_hit:        1'b0
  };

  bwds_state_t st;
  bwds_state_t next_st;
  logic [15:0] ssts_view;
  logic        serr_event;

  // Generic inclusive window check, shared by I/O and memory decode
  function automatic logic in_window(input logic [31:0] addr,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
    in_window = (addr >= lo) && (addr <= hi);
  endfunction : in_window

  // Fixed fields come from the reset image, so only 14:12 live
  assign ssts_view = SS_RST | {1'b0, st.err, 12'h000};
  // Only the second and third stage feed the edge detect
  assign serr_event = st.serr_sync[1] & ~st.serr_sync[2];

  always_comb begin
    next_st = st;
    next_st.serr_sync = {st.serr_sync[1:0], LINK_SERR_IN};

    // Window decode, registered so hits stand one cycle after the request
    next_st.io_hit = IO_REQ_IN && in_window({16'h0000, IO_ADDR_IN},
      {16'h0000, st.io_base_field, `BWDS_IO_LOW_ZERO},
      {16'h0000, st.io_limit_field, `BWDS_IO_LOW_ONES});
    next_st.mem_hit = MEM_REQ_IN && in_window(MEM_ADDR_IN,
      {st.mem_base_field, `BWDS_MEM_LOW_ZERO},
      {MEM_LIMIT_IN, `BWDS_MEM_LOW_ONES});

    // Write-one-to-clear first; a new event below wins over it
    if (REG_WR_IN && REG_ADDR_IN == `BWDS_OFF_SSTS_HI) begin
      next_st.err = st.err & ~bwds_err_t'(REG_WDATA_IN[6:4]);
    end
    if (serr_event) begin
      next_st.err.system_error_received_flag = 1'b1;
    end
    if (MASTER_ABORT_IN) begin
      next_st.err.master_abort_received_flag = 1'b1;
    end
    if (TARGET_ABORT_IN) begin
      next_st.err.target_abort_received_flag = 1'b1;
    end

    // Reserved nibbles are simply not stored
    if (REG_WR_IN) begin
      if (REG_ADDR_IN == `BWDS_OFF_IO_BASE_FIELD) begin
        next_st.io_base_field = REG_WDATA_IN[7:4];
      end else if (REG_ADDR_IN == `BWDS_OFF_IOLIM) begin
        next_st.io_limit_field = REG_WDATA_IN[7:4];
      end else if (REG_ADDR_IN == `BWDS_OFF_MBASE_LO) begin
        next_st.mem_base_field[3:0] = REG_WDATA_IN[7:4];
      end else if (REG_ADDR_IN == `BWDS_OFF_MBASE_HI) begin
        next_st.mem_base_field[11:4] = REG_WDATA_IN;
      end
    end

    // Read data valid in the cycle after the strobe only
    next_st.rd_data = 8'h00;
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == `BWDS_OFF_LAT) begin
        next_st.rd_data = `BWDS_RST_LAT;
      end else if (REG_ADDR_IN == `BWDS_OFF_IO_BASE_FIELD) begin
        next_st.rd_data = {st.io_base_field, 4'h0};
      end else if (REG_ADDR_IN == `BWDS_OFF_IOLIM) begin
        next_st.rd_data = {st.io_limit_field, 4'h0};
      end else if (REG_ADDR_IN == `BWDS_OFF_SSTS_LO) begin
        next_st.rd_data = ssts_view[7:0];
      end else if (REG_ADDR_IN == `BWDS_OFF_SSTS_HI) begin
        next_st.rd_data = ssts_view[15:8];
      end else if (REG_ADDR_IN == `BWDS_OFF_MBASE_LO) begin
        next_st.rd_data = {st.mem_base_field[3:0], 4'h0};
      end else if (REG_ADDR_IN == `BWDS_OFF_MBASE_HI) begin
        next_st.rd_data = st.mem_base_field[11:4];
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA_OUT = st.rd_data;
  assign IO_HIT_OUT    = st.io_hit;
  assign MEM_HIT_OUT   = st.mem_hit;

  // Checks
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  a_io_window_hit: assert property (
    IO_REQ_IN && IO_ADDR_IN[15:12] >= st.io_base_field
      && IO_ADDR_IN[15:12] <= st.io_limit_field |=> IO_HIT_OUT)
    else $error("I/O cycle inside window not forwarded");

  a_io_window_miss: assert property (
    !IO_REQ_IN || IO_ADDR_IN[15:12] < st.io_base_field
      || IO_ADDR_IN[15:12] > st.io_limit_field |=> !IO_HIT_OUT)
    else $error("I/O cycle outside window forwarded");

  a_mem_window_hit: assert property (
    MEM_REQ_IN && MEM_ADDR_IN[31:20] >= st.mem_base_field
      && MEM_ADDR_IN[31:20] <= MEM_LIMIT_IN |=> MEM_HIT_OUT)
    else $error("Memory cycle inside window not forwarded");

  a_mem_window_miss: assert property (
    MEM_REQ_IN && (MEM_ADDR_IN[31:20] < st.mem_base_field
      || MEM_ADDR_IN[31:20] > MEM_LIMIT_IN) |=> !MEM_HIT_OUT)
    else $error("Memory cycle outside window forwarded");

  a_io_base_write: assert property (
    REG_WR_IN && REG_ADDR_IN == `BWDS_OFF_IO_BASE_FIELD ##1 REG_RD_IN
      && REG_ADDR_IN == `BWDS_OFF_IO_BASE_FIELD
      |=> REG_RDATA_OUT == {$past(REG_WDATA_IN[7:4], 2), 4'h0})
    else $error("I/O base readback wrong");

  a_io_limit_write: assert property (
    REG_WR_IN && REG_ADDR_IN == `BWDS_OFF_IOLIM
      |=> st.io_limit_field == $past(REG_WDATA_IN[7:4]))
    else $error("I/O limit not stored");

  a_mem_base_read: assert property (
    REG_RD_IN && REG_ADDR_IN == `BWDS_OFF_MBASE_LO
      |=> REG_RDATA_OUT[3:0] == 4'h0
        && REG_RDATA_OUT[7:4] == $past(st.mem_base_field[3:0]))
    else $error("Memory base low byte wrong");

  a_flag_w1c_hold: assert property (
    st.err.system_error_received_flag && REG_WR_IN
      && REG_ADDR_IN == `BWDS_OFF_SSTS_HI && !REG_WDATA_IN[6]
      |=> st.err.system_error_received_flag)
    else $error("Flag lost on write of zero");

  a_serr_flag_set: assert property (
    $rose(LINK_SERR_IN) |-> ##3 st.err.system_error_received_flag)
    else $error("System error flag not set after sync");

  a_abort_flags_set: assert property (
    MASTER_ABORT_IN && TARGET_ABORT_IN
      |=> st.err.master_abort_received_flag && st.err.target_abort_received_flag)
    else $error("Abort flags not set");

  a_master_abort_win: assert property (
    MASTER_ABORT_IN && REG_WR_IN && REG_ADDR_IN == `BWDS_OFF_SSTS_HI
      |=> st.err.master_abort_received_flag)
    else $error("Clear beat a new master abort");

  a_status_fixed_hi: assert property (
    REG_RD_IN && REG_ADDR_IN == `BWDS_OFF_SSTS_HI
      |=> !REG_RDATA_OUT[7] && REG_RDATA_OUT[3:0] == 4'h2)
    else $error("Fixed high status bits wrong");

  a_status_fixed_lo: assert property (
    REG_RD_IN && REG_ADDR_IN == `BWDS_OFF_SSTS_LO |=> REG_RDATA_OUT == 8'ha0)
    else $error("Fixed low status bits wrong");

  a_latency_zero: assert property (
    REG_RD_IN && REG_ADDR_IN == `BWDS_OFF_LAT |=> REG_RDATA_OUT == 8'h00)
    else $error("Latency timer byte not zero");

  c_io_hit: cover property (IO_REQ_IN ##1 IO_HIT_OUT);
  c_mem_hit: cover property (MEM_REQ_IN ##1 MEM_HIT_OUT);
  c_serr_clear: cover property (st.err.system_error_received_flag ##1
    !st.err.system_error_received_flag);
  c_set_and_clear: cover property (MASTER_ABORT_IN && REG_WR_IN
    && REG_ADDR_IN == `BWDS_OFF_SSTS_HI);

endmodule : bwds_top
`default_nettype wire
